// ---- rtl/csd_clock_ctrl.sv ----
// Clock source selection, CPU divider and peripheral clock generation.
// Assumes oscillator levels arrive synchronous to CLK_SYS and far slower than it;
// clock outputs are registered square waves rebuilt from edges of those levels.
// Summary of operation
// - Fast oscillator enable resets to 0; writing 1 starts it, 0 stops it.
// - On-chip select bit: 0 picks slow oscillator, 1 picks fast oscillator.
// - Main oscillator is stopped in and after reset until software enables it.
// - Feedback resistor is disconnected in stop mode, connected otherwise.
// - Main stop bit set to 1 stops the main oscillator.
// - An external clock on the oscillator input is not stopped by main stop.
// - After reset the CPU runs from slow on-chip clock divided by 8.
// - With detection 11b and main clock lost, switch to on-chip clock and force slow stop to 0.
// - Fast oscillator trimmed through two separate trim registers.
// - Source select 0 picks main clock, 1 picks on-chip clock.
// - Divide-by-8 bit overrides; else field gives 1, 2, 4 or 16.
// - Entering stop from main-clock modes sets the divide-by-8 bit.
// - Peripheral clocks are system clock divided by 1, 2, 4, 8 and 32.
// - Peripheral clocks stop during wait when the stop-in-wait bit is 1.
// - Ring clock follows on-chip clock; slow ring is it divided by 128.
// - Fast ring clock comes from fast oscillator while its enable is 1.
// - Watchdog ring clock runs while slow stop is 0, also in wait and protect.
// - High-speed mode gives the main clock undivided to the CPU.
// - On-chip clock comes from fast or slow oscillator per enable and select.
// - Ring clocks usable on main clock when either on-chip oscillator runs.
// - While on-chip clock is selected, slow stop is forced 0.
`timescale 1ns/1ps
`default_nettype none

module csd_clock_ctrl (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Oscillator levels and power modes
  input wire logic MAIN_OSC_IN,
  input wire logic FAST_OSC_IN,
  input wire logic SLOW_OSC_IN,
  input wire logic EXT_CLOCK_MODE,
  input wire logic MAIN_OSC_LOST,
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  input wire logic COUNT_PROTECT,
  // Oscillator controls
  output logic MAIN_OSC_EN,
  output logic FEEDBACK_CONNECT,
  output logic MAIN_DRIVE_HIGH,
  output logic OSC_OUT_HOLD_HIGH,
  output logic FAST_OSC_EN,
  output logic SLOW_OSC_EN,
  output logic [7:0] FAST_OSC_TRIM_A,
  output logic [7:0] FAST_OSC_TRIM_B,
  // Generated clocks and status
  output logic CPU_CLK,
  output logic [4:0] PERIPH_CLK,
  output logic RING_CLK,
  output logic SLOW_RING_CLK,
  output logic FAST_RING_CLK,
  output logic WATCHDOG_RING_CLK,
  output logic RING_AVAILABLE,
  output logic HIGH_SPEED_MODE
);

  csd_pkg::csd_state_t s_reg;
  csd_pkg::csd_state_t s_next;

  // Divider code from the three division bits
  function automatic logic [2:0] div_code(input logic div8, input logic hi, input logic lo);
    logic [2:0] code;
    code = csd_pkg::DIV_1;
    if (div8) begin
      code = csd_pkg::DIV_8;
    end else begin
      case ({hi, lo})
        2'h0: code = csd_pkg::DIV_1;
        2'h1: code = csd_pkg::DIV_2;
        2'h2: code = csd_pkg::DIV_4;
        default: code = csd_pkg::DIV_16;
      endcase
    end
    return code;
  endfunction

  // Level change of an oscillator input, qualified by its run enable
  function automatic logic half_tick(input logic run, input logic now, input logic prev);
    return run & (now ^ prev);
  endfunction

  logic hra_en;
  logic hra_sel;
  logic slow_on;
  logic main_run;
  logic main_edge;
  logic fast_edge;
  logic slow_edge;
  logic onchip_edge;
  logic onchip_lvl;
  logic sys_edge;
  logic old_src_dead;
  logic pclk_gate;

  // Oscillator run conditions
  assign hra_en = s_reg.fast_oscillator_control[csd_pkg::HRA_EN];
  assign hra_sel = s_reg.fast_oscillator_control[csd_pkg::HRA_SEL];
  assign slow_on = ~s_reg.cm1[csd_pkg::CM1_SLOW_STOP];
  // External clock ignores the main stop bit; only stop mode removes it
  assign main_run = EXT_CLOCK_MODE ? ~STOP_MODE :
    (s_reg.cm1[csd_pkg::CM1_PIN_FUNC] & ~s_reg.cm0[csd_pkg::CM0_MAIN_STOP] & ~STOP_MODE);

  // Edge detection on the oscillator levels
  assign main_edge = half_tick(main_run, MAIN_OSC_IN, s_reg.main_q);
  assign fast_edge = half_tick(hra_en & ~STOP_MODE, FAST_OSC_IN, s_reg.fast_q);
  assign slow_edge = half_tick(slow_on & ~STOP_MODE, SLOW_OSC_IN, s_reg.slow_q);
  assign onchip_edge = hra_sel ? fast_edge : slow_edge;
  assign onchip_lvl = hra_sel ? (FAST_OSC_IN & hra_en) : (SLOW_OSC_IN & slow_on);
  assign sys_edge = s_reg.sys_sel ? onchip_edge : main_edge;
  // A dead old source would never give the edge the switch waits for
  assign old_src_dead = s_reg.sys_sel ? 1'b0 : (~main_run | MAIN_OSC_LOST);
  assign pclk_gate = WAIT_MODE & s_reg.cm0[csd_pkg::CM0_PCLK_WAIT];

  // Next-state logic for registers and clock generators
  always_comb begin
    s_next = s_reg;
    s_next.main_q = MAIN_OSC_IN;
    s_next.fast_q = FAST_OSC_IN;
    s_next.slow_q = SLOW_OSC_IN;
    s_next.stop_q = STOP_MODE;
    s_next.rdata = csd_pkg::READ_ZERO;

    // Register writes
    if (WR) begin
      case (ADDR)
        csd_pkg::ADDR_CM0: s_next.cm0 = WDATA;
        csd_pkg::ADDR_CM1: begin
          s_next.cm1 = WDATA;
          if (s_reg.oscillation_detect_control[csd_pkg::OCD_SRC] | COUNT_PROTECT) begin
            s_next.cm1[csd_pkg::CM1_SLOW_STOP] = s_reg.cm1[csd_pkg::CM1_SLOW_STOP];
          end
        end
        csd_pkg::ADDR_OCD: s_next.oscillation_detect_control = (WDATA[3:0] & csd_pkg::MASK_OCD) | (s_reg.oscillation_detect_control & ~csd_pkg::MASK_OCD);
        csd_pkg::ADDR_FAST_OSCILLATOR_CONTROL: s_next.fast_oscillator_control = WDATA & csd_pkg::MASK_FAST_OSCILLATOR_CONTROL;
        csd_pkg::ADDR_FAST_OSC_TRIM_A: s_next.fast_osc_trim_a = WDATA;
        csd_pkg::ADDR_FAST_OSC_TRIM_B: s_next.fast_osc_trim_b = WDATA;
        default: s_next.cm0 = s_next.cm0;
      endcase
    end

    // Register reads, data in the following cycle
    if (RD) begin
      case (ADDR)
        csd_pkg::ADDR_CM0: s_next.rdata = s_reg.cm0;
        csd_pkg::ADDR_CM1: s_next.rdata = s_reg.cm1;
        csd_pkg::ADDR_OCD: s_next.rdata = {4'h0, s_reg.oscillation_detect_control};
        csd_pkg::ADDR_FAST_OSCILLATOR_CONTROL: s_next.rdata = s_reg.fast_oscillator_control;
        csd_pkg::ADDR_FAST_OSC_TRIM_A: s_next.rdata = s_reg.fast_osc_trim_a;
        csd_pkg::ADDR_FAST_OSC_TRIM_B: s_next.rdata = s_reg.fast_osc_trim_b;
        default: s_next.rdata = csd_pkg::READ_ZERO;
      endcase
    end

    // Main clock loss: hardware takes over, beating any write in the same cycle
    if (s_reg.oscillation_detect_control[csd_pkg::OCD_DET_HI:csd_pkg::OCD_DET_LO] == csd_pkg::DET_ENABLED &&
        !s_reg.oscillation_detect_control[csd_pkg::OCD_SRC] && MAIN_OSC_LOST) begin
      s_next.oscillation_detect_control[csd_pkg::OCD_SRC] = 1'b1;
      s_next.oscillation_detect_control[csd_pkg::OCD_STOPPED] = 1'b1;
      s_next.cm1[csd_pkg::CM1_SLOW_STOP] = 1'b0;
    end

    // Slow oscillator must run while it may feed the system clock
    if (s_next.oscillation_detect_control[csd_pkg::OCD_SRC]) begin
      s_next.cm1[csd_pkg::CM1_SLOW_STOP] = 1'b0;
    end

    // Stop entry from a main-clock mode forces divide-by-8 and strong drive
    if (STOP_MODE && !s_reg.stop_q && !s_reg.oscillation_detect_control[csd_pkg::OCD_SRC]) begin
      s_next.cm0[csd_pkg::CM0_DIV8] = 1'b1;
      s_next.cm1[csd_pkg::CM1_DRIVE] = 1'b1;
    end

    // System clock counter; source swaps as the f1 phase falls, or at once when the old main source is dead
    if (sys_edge) begin
      s_next.sys_cnt = s_reg.sys_cnt + csd_pkg::SYS_CNT_ONE;
    end
    if ((sys_edge && !s_next.sys_cnt[csd_pkg::TAP_F1]) || old_src_dead) begin
      s_next.sys_sel = s_reg.oscillation_detect_control[csd_pkg::OCD_SRC];
    end

    // CPU divider counter, frozen while the CPU waits
    if (sys_edge && !WAIT_MODE) begin
      s_next.cpu_cnt = s_reg.cpu_cnt + csd_pkg::CPU_CNT_ONE;
      // New ratio taken only at full wrap, when every tap is low
      if (s_next.cpu_cnt == csd_pkg::CPU_CNT_ZERO) begin
        s_next.div_act = div_code(s_reg.cm0[csd_pkg::CM0_DIV8], s_reg.cm1[csd_pkg::CM1_DIV_HI],
          s_reg.cm1[csd_pkg::CM1_DIV_LO]);
      end
    end
    s_next.cpu_clk = s_next.cpu_cnt[s_next.div_act] & ~STOP_MODE;

    // Peripheral clocks from the system counter taps
    s_next.pclk[0] = s_next.sys_cnt[csd_pkg::TAP_F1] & ~pclk_gate;
    s_next.pclk[1] = s_next.sys_cnt[csd_pkg::TAP_F2] & ~pclk_gate;
    s_next.pclk[2] = s_next.sys_cnt[csd_pkg::TAP_F4] & ~pclk_gate;
    s_next.pclk[3] = s_next.sys_cnt[csd_pkg::TAP_F8] & ~pclk_gate;
    s_next.pclk[4] = s_next.sys_cnt[csd_pkg::TAP_F32] & ~pclk_gate;

    // Ring clocks ignore wait mode
    if (onchip_edge && onchip_lvl) begin
      s_next.ring_cnt = s_reg.ring_cnt + csd_pkg::RING_CNT_ONE;
    end
    s_next.ring_clk = onchip_lvl & ~STOP_MODE;
    s_next.ring_slow = s_next.ring_cnt[csd_pkg::TAP_RING128];
    s_next.fast_ring = FAST_OSC_IN & hra_en & ~STOP_MODE;
    // Watchdog clock also survives stop attempts in count-source-protect
    s_next.wdt_ring = SLOW_OSC_IN & slow_on & (~STOP_MODE | COUNT_PROTECT);
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_reg <= '0;
      s_reg.cm0 <= csd_pkg::RST_CM0;
      s_reg.cm1 <= csd_pkg::RST_CM1;
      s_reg.oscillation_detect_control <= csd_pkg::RST_OCD;
      s_reg.fast_oscillator_control <= csd_pkg::RST_FAST_OSCILLATOR_CONTROL;
      s_reg.fast_osc_trim_a <= csd_pkg::RST_TRIM;
      s_reg.fast_osc_trim_b <= csd_pkg::RST_TRIM;
      s_reg.sys_sel <= 1'b1;
      s_reg.div_act <= csd_pkg::DIV_8;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign RDATA = s_reg.rdata;
  assign MAIN_OSC_EN = main_run;
  assign FEEDBACK_CONNECT = ~STOP_MODE;
  assign MAIN_DRIVE_HIGH = s_reg.cm1[csd_pkg::CM1_DRIVE];
  assign OSC_OUT_HOLD_HIGH = s_reg.cm1[csd_pkg::CM1_PIN_FUNC] & (STOP_MODE | s_reg.cm0[csd_pkg::CM0_MAIN_STOP]);
  assign FAST_OSC_EN = hra_en & ~STOP_MODE;
  assign SLOW_OSC_EN = slow_on & (~STOP_MODE | COUNT_PROTECT);
  assign FAST_OSC_TRIM_A = s_reg.fast_osc_trim_a;
  assign FAST_OSC_TRIM_B = s_reg.fast_osc_trim_b;
  assign CPU_CLK = s_reg.cpu_clk;
  assign PERIPH_CLK = s_reg.pclk;
  assign RING_CLK = s_reg.ring_clk;
  assign SLOW_RING_CLK = s_reg.ring_slow;
  assign FAST_RING_CLK = s_reg.fast_ring;
  assign WATCHDOG_RING_CLK = s_reg.wdt_ring;
  assign RING_AVAILABLE = slow_on | hra_en;
  assign HIGH_SPEED_MODE = ~s_reg.sys_sel & (s_reg.div_act == csd_pkg::DIV_1) & main_run;

endmodule

`default_nettype wire

// ---- rtl/csd_pkg.sv ----
// Constants for the clock source and divider control block.
// Assumes an 8-bit register port and oscillator levels synchronous to the system clock.
package csd_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CM0 = 8'h06;
  localparam logic [7:0] ADDR_CM1 = 8'h07;
  localparam logic [7:0] ADDR_OCD = 8'h0C;
  localparam logic [7:0] ADDR_FAST_OSCILLATOR_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_FAST_OSC_TRIM_A = 8'h21;
  localparam logic [7:0] ADDR_FAST_OSC_TRIM_B = 8'h22;
  // Reset values
  localparam logic [7:0] RST_CM0 = 8'h68;
  localparam logic [7:0] RST_CM1 = 8'h20;
  localparam logic [3:0] RST_OCD = 4'h4;
  localparam logic [7:0] RST_FAST_OSCILLATOR_CONTROL = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Writable masks
  localparam logic [7:0] MASK_FAST_OSCILLATOR_CONTROL = 8'h03;
  localparam logic [3:0] MASK_OCD = 4'h7;
  // Field positions
  localparam int CM0_PCLK_WAIT = 2;
  localparam int CM0_MAIN_STOP = 5;
  localparam int CM0_DIV8 = 6;
  localparam int CM1_PIN_FUNC = 3;
  localparam int CM1_SLOW_STOP = 4;
  localparam int CM1_DRIVE = 5;
  localparam int CM1_DIV_LO = 6;
  localparam int CM1_DIV_HI = 7;
  localparam int HRA_EN = 0;
  localparam int HRA_SEL = 1;
  localparam int OCD_DET_LO = 0;
  localparam int OCD_DET_HI = 1;
  localparam int OCD_SRC = 2;
  localparam int OCD_STOPPED = 3;
  localparam logic [1:0] DET_ENABLED = 2'h3;
  // CPU divider codes: index of the counter bit used as CPU clock
  localparam logic [2:0] DIV_1 = 3'h0;
  localparam logic [2:0] DIV_2 = 3'h1;
  localparam logic [2:0] DIV_4 = 3'h2;
  localparam logic [2:0] DIV_8 = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h4;
  // Counter widths and tap positions
  localparam int SYS_CNT_W = 6;
  localparam int CPU_CNT_W = 5;
  localparam int RING_CNT_W = 7;
  localparam int TAP_F1 = 0;
  localparam int TAP_F2 = 1;
  localparam int TAP_F4 = 2;
  localparam int TAP_F8 = 3;
  localparam int TAP_F32 = 5;
  localparam int TAP_RING128 = 6;
  localparam logic [SYS_CNT_W-1:0] SYS_CNT_ONE = 6'h01;
  localparam logic [CPU_CNT_W-1:0] CPU_CNT_ONE = 5'h01;
  localparam logic [CPU_CNT_W-1:0] CPU_CNT_ZERO = 5'h00;
  localparam logic [RING_CNT_W-1:0] RING_CNT_ONE = 7'h01;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] cm0;
    logic [7:0] cm1;
    logic [3:0] oscillation_detect_control;
    logic [7:0] fast_oscillator_control;
    logic [7:0] fast_osc_trim_a;
    logic [7:0] fast_osc_trim_b;
    logic [7:0] rdata;
    logic main_q;
    logic fast_q;
    logic slow_q;
    logic stop_q;
    logic sys_sel;
    logic [2:0] div_act;
    logic [SYS_CNT_W-1:0] sys_cnt;
    logic [CPU_CNT_W-1:0] cpu_cnt;
    logic [RING_CNT_W-1:0] ring_cnt;
    logic cpu_clk;
    logic [4:0] pclk;
    logic ring_clk;
    logic ring_slow;
    logic fast_ring;
    logic wdt_ring;
  } csd_state_t;
endpackage

// ---- tb/csd_clock_ctrl_chk.sv ----
// Assertion checker for the clock source and divider control block.
// Sees only the top ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module csd_clock_ctrl_chk (
  // Clock, reset and register port
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Modes and watched outputs
  input wire logic EXT_CLOCK_MODE,
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  input wire logic COUNT_PROTECT,
  input wire logic MAIN_OSC_EN,
  input wire logic FEEDBACK_CONNECT,
  input wire logic FAST_OSC_EN,
  input wire logic SLOW_OSC_EN,
  input wire logic [7:0] FAST_OSC_TRIM_A,
  input wire logic [7:0] FAST_OSC_TRIM_B,
  input wire logic [4:0] PERIPH_CLK,
  input wire logic RING_AVAILABLE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Register port steps on the fast oscillator control register
  sequence s_wr_fast;
    WR && ADDR == csd_pkg::ADDR_FAST_OSCILLATOR_CONTROL;
  endsequence
  sequence s_rd_fast;
    RD && ADDR == csd_pkg::ADDR_FAST_OSCILLATOR_CONTROL;
  endsequence
  AST_RESET_OFF: assert property ($fell(SRST) |-> !FAST_OSC_EN && (EXT_CLOCK_MODE || !MAIN_OSC_EN))
    else $error("oscillator running right after reset");
  AST_FAST_WRITE: assert property (s_wr_fast ##1 !STOP_MODE |-> FAST_OSC_EN == $past(WDATA[0]))
    else $error("fast oscillator enable does not follow write");
  AST_READ_BACK: assert property (s_wr_fast ##2 s_rd_fast |=> RDATA == ($past(WDATA, 3) & 8'h03))
    else $error("fast oscillator control read back wrong");
  AST_TRIM_A: assert property (WR && ADDR == csd_pkg::ADDR_FAST_OSC_TRIM_A |=> FAST_OSC_TRIM_A == $past(WDATA))
    else $error("trim a not applied");
  AST_TRIM_B: assert property (WR && ADDR == csd_pkg::ADDR_FAST_OSC_TRIM_B |=> FAST_OSC_TRIM_B == $past(WDATA))
    else $error("trim b not applied");
  AST_FEEDBACK: assert property (FEEDBACK_CONNECT != STOP_MODE)
    else $error("feedback resistor wrong for stop state");
  AST_EXT_RUNS: assert property (EXT_CLOCK_MODE && !STOP_MODE |-> MAIN_OSC_EN)
    else $error("external clock gated by main stop");
  AST_RING_AVAIL: assert property (s_wr_fast and WDATA[0] |=> RING_AVAILABLE)
    else $error("ring clocks unavailable with fast oscillator on");
  AST_SLOW_STOP: assert property (STOP_MODE && !COUNT_PROTECT |-> !SLOW_OSC_EN)
    else $error("slow oscillator running in stop");
  AST_F2_DIV: assert property ($changed(PERIPH_CLK[1]) && !WAIT_MODE && !$past(WAIT_MODE) && !$past(WAIT_MODE, 2)
    |-> $fell(PERIPH_CLK[0]))
    else $error("f2 not derived from f1");
endmodule
`default_nettype wire

// ---- tb/csd_osc_model.sv ----
// Oscillator model: crystal and the two on-chip oscillators as slow levels.
// Assumes the bench clock; a stopped or dead oscillator freezes its level.
`timescale 1ns/1ps
`default_nettype none
module csd_osc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Enables and injected fault
  input wire logic main_en,
  input wire logic fast_en,
  input wire logic slow_en,
  input wire logic main_dead,
  // Oscillator levels
  output logic main_lvl,
  output logic fast_lvl,
  output logic slow_lvl
);
  logic [2:0] cm, cf, cs;
  // Half periods of 2, 3 and 4 cycles, each only while enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      {cm, cf, cs} <= 9'h000;
      {main_lvl, fast_lvl, slow_lvl} <= 3'h0;
    end else begin
      if (main_en && !main_dead) begin
        cm <= (cm == 3'h1) ? 3'h0 : cm + 3'h1;
        main_lvl <= main_lvl ^ (cm == 3'h1);
      end
      if (fast_en) begin
        cf <= (cf == 3'h2) ? 3'h0 : cf + 3'h1;
        fast_lvl <= fast_lvl ^ (cf == 3'h2);
      end
      if (slow_en) begin
        cs <= (cs == 3'h3) ? 3'h0 : cs + 3'h1;
        slow_lvl <= slow_lvl ^ (cs == 3'h3);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/csd_clock_ctrl_bench.sv ----
// Bench for the clock block: register tasks plus period measurements.
// Assumes the oscillator model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module csd_clock_ctrl_bench;
  logic clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, ext = 1'b0, lost = 1'b0;
  logic waitm = 1'b0, stopm = 1'b0, dead = 1'b0, cp = 1'b0, drv, hold, wdr;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, trim_a, trim_b;
  logic m_lvl, f_lvl, s_lvl, m_en, f_en, s_en, cpu, rc, src, frc, ravail, hsm;
  logic [4:0] pclk, acc;
  wire logic [9:0] probe = {wdr, frc, rc, src, cpu, pclk};
  int n_errors = 0, checks_done = 0;
  localparam int dv [5] = '{0, 1, 2, 4, 5};
  localparam logic [15:0] rv [7] = '{16'h0668, 16'h0720, 16'h0C04, 16'h2000, 16'h2100, 16'h2200, 16'h3000};
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  csd_clock_ctrl i_dut (.CLK_SYS(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .MAIN_OSC_IN(m_lvl), .FAST_OSC_IN(f_lvl), .SLOW_OSC_IN(s_lvl), .EXT_CLOCK_MODE(ext),
    .MAIN_OSC_LOST(lost), .WAIT_MODE(waitm), .STOP_MODE(stopm), .COUNT_PROTECT(cp), .MAIN_OSC_EN(m_en),
    .FEEDBACK_CONNECT(), .MAIN_DRIVE_HIGH(drv), .OSC_OUT_HOLD_HIGH(hold), .FAST_OSC_EN(f_en), .SLOW_OSC_EN(s_en),
    .FAST_OSC_TRIM_A(trim_a), .FAST_OSC_TRIM_B(trim_b), .CPU_CLK(cpu), .PERIPH_CLK(pclk), .RING_CLK(rc),
    .SLOW_RING_CLK(src), .FAST_RING_CLK(frc), .WATCHDOG_RING_CLK(wdr), .RING_AVAILABLE(ravail), .HIGH_SPEED_MODE(hsm));
  csd_osc_model i_osc (.clk(clk), .srst(srst), .main_en(m_en), .fast_en(f_en), .slow_en(s_en), .main_dead(dead),
    .main_lvl(m_lvl), .fast_lvl(f_lvl), .slow_lvl(s_lvl));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bus cycles; the idle cycle after each keeps strobes single
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check($sformatf("reg %0h", a), 16'(rdata), 16'(exp));
    @(posedge clk);
  endtask
  // Period of one probe bit between its second and third rise
  task automatic per(input int idx, input logic [15:0] exp);
    int t;
    int r;
    int st;
    logic p;
    t = 0;
    r = 0;
    st = 0;
    p = probe[idx];
    while (r < 3 && t < 4000) begin
      @(posedge clk);
      #1;
      t++;
      if (probe[idx] && !p) r++;
      if (probe[idx] && !p && r == 2) st = t;
      p = probe[idx];
    end
    if (r < 3) begin
      n_errors++;
      tally_and_finish();
    end else check($sformatf("period %0d", idx), 16'(t - st), exp);
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    check("main enable", 16'(m_en), 16'h0000);
    per(5, 16'd64);
    $display("test reset done");
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h03);
    check("fast enable", 16'(f_en), 16'h0001);
    wr(8'h21, 8'hA5);
    wr(8'h22, 8'h5A);
    rd(8'h21, 8'hA5);
    rd(8'h22, 8'h5A);
    check("trim b", 16'(trim_b), 16'h005A);
    repeat (140) @(posedge clk);
    per(7, 16'd6);
    per(8, 16'd6);
    wr(8'h20, 8'h01);
    repeat (140) @(posedge clk);
    per(7, 16'd8);
    wr(8'h20, 8'h00);
    check("fast enable", 16'(f_en), 16'h0000);
    $display("test fast oscillator done");
    wr(8'h06, 8'h28);
    for (int k = 0; k < 4; k++) begin
      wr(8'h07, {k[1:0], 6'h20});
      repeat (140) @(posedge clk);
      per(5, 16'd8 << dv[k]);
    end
    for (int i = 0; i < 5; i++) per(i, 16'd8 << (i == 4 ? 5 : i));
    per(6, 16'd1024);
    $display("test dividers done");
    // Wait with peripheral clock stop enabled
    wr(8'h06, 8'h2C);
    waitm <= 1'b1;
    repeat (3) @(posedge clk);
    acc = 5'h00;
    repeat (40) @(posedge clk) acc |= pclk;
    check("wait periph", 16'(acc), 16'h0000);
    per(7, 16'd8);
    per(9, 16'd8);
    waitm <= 1'b0;
    $display("test wait done");
    // Main clock start, switch over and stop entry
    wr(8'h07, 8'h08);
    wr(8'h06, 8'h08);
    check("main enable", 16'(m_en), 16'h0001);
    repeat (20) @(posedge clk);
    wr(8'h0C, 8'h00);
    repeat (140) @(posedge clk);
    per(0, 16'd4);
    per(5, 16'd4);
    check("high speed", 16'(hsm), 16'h0001);
    stopm <= 1'b1;
    repeat (3) @(posedge clk);
    stopm <= 1'b0;
    rd(8'h06, 8'h48);
    check("drive high", 16'(drv), 16'h0001);
    $display("test main clock done");
    // Main oscillation lost with detection on
    repeat (20) @(posedge clk);
    wr(8'h0C, 8'h03);
    dead <= 1'b1;
    lost <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h0C, 8'h0F);
    check("slow enable", 16'(s_en), 16'h0001);
    lost <= 1'b0;
    dead <= 1'b0;
    wr(8'h07, 8'h38);
    rd(8'h07, 8'h28);
    wr(8'h06, 8'h28);
    check("main enable", 16'(m_en), 16'h0000);
    check("out hold", 16'(hold), 16'h0001);
    ext <= 1'b1;
    cp <= 1'b1;
    @(posedge clk);
    #1 check("ext clock", 16'(m_en), 16'h0001);
    @(posedge clk);
    stopm <= 1'b1;
    @(posedge clk);
    #1 check("protect slow", 16'(s_en), 16'h0001);
    @(posedge clk);
    ext <= 1'b0;
    cp <= 1'b0;
    stopm <= 1'b0;
    $display("test loss and external clock done");
    @(posedge clk);
    tally_and_finish();
  end
endmodule
bind csd_clock_ctrl csd_clock_ctrl_chk i_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .EXT_CLOCK_MODE(EXT_CLOCK_MODE), .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE),
  .COUNT_PROTECT(COUNT_PROTECT), .MAIN_OSC_EN(MAIN_OSC_EN), .FEEDBACK_CONNECT(FEEDBACK_CONNECT),
  .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN), .FAST_OSC_TRIM_A(FAST_OSC_TRIM_A),
  .FAST_OSC_TRIM_B(FAST_OSC_TRIM_B), .PERIPH_CLK(PERIPH_CLK), .RING_AVAILABLE(RING_AVAILABLE));
`default_nettype wire
